// ===== design/pllhc_pkg.sv
package pllhc_pkg;
  typedef enum logic [2:0] {
    PLLHC_CS_IDLE    = 3'b000,
    PLLHC_CS_ALIGN   = 3'b001,
    PLLHC_CS_RUN     = 3'b010,
    PLLHC_CS_RELEASE = 3'b011,
    PLLHC_CS_CLOSE   = 3'b100
  } pllhc_cal_e;
  typedef logic [7:0] pllhc_byte_t;
endpackage

// ===== design/pllhc_regs.svh
`ifndef PLLHC_REGS_SVH
`define PLLHC_REGS_SVH
// register indices; byte address is four times the index
`define PLLHC_IDX_PLL_CFG   10'h018
`define PLLHC_IDX_PIN_CTL   10'h01A
`define PLLHC_IDX_REF_SEL   10'h01C
`define PLLHC_IDX_HO_CTL    10'h01D
`define PLLHC_IDX_STATUS    10'h01F
`define PLLHC_IDX_CH0       10'h191
`define PLLHC_IDX_CH1       10'h194
`define PLLHC_IDX_CH2       10'h197
`define PLLHC_IDX_CH3       10'h19A
`define PLLHC_IDX_UPDATE    10'h232
// pll_cfg fields
`define PLLHC_CAL_BIT       0
`define PLLHC_CALDIV_LSB    1
`define PLLHC_DET_DIS_BIT   3
`define PLLHC_WIN_BIT       4
`define PLLHC_LDC_LSB       5
// pin control fields
`define PLLHC_LDMODE_LSB    0
`define PLLHC_REFTHR_BIT    6
`define PLLHC_PIN_CHARGED   6'h04
// holdover control fields
`define PLLHC_HO_EN_BIT     0
`define PLLHC_HO_EXT_BIT    1
`define PLLHC_COMP_EN_BIT   3
// channel ignore-alignment bit
`define PLLHC_IGN_BIT       6
// status fields
`define PLLHC_ST_PRI_BIT    0
`define PLLHC_ST_SEC_BIT    1
`define PLLHC_ST_VCO_BIT    2
`define PLLHC_ST_LOCK_BIT   3
`define PLLHC_ST_HIZ_BIT    4
`define PLLHC_ST_BUSY_BIT   5
`define PLLHC_ST_DONE_BIT   6
// reset values
`define PLLHC_RST_BYTE      8'h00
// lock detect counts per code
`define PLLHC_LDC0          8'h05
`define PLLHC_LDC1          8'h10
`define PLLHC_LDC2          8'h40
`define PLLHC_LDC3          8'hFF
// calibration length in calibration clock ticks
`define PLLHC_CAL_TICKS     4400
`endif

// ===== design/pllhc_top.sv
// The register offsets and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "pllhc_regs.svh"
module pllhc_top #(
  parameter int CAL_TICKS = `PLLHC_CAL_TICKS
) (
  input  wire logic              i_clk,
  input  wire logic              i_srst,
  input  wire logic              i_ce,
  input  wire logic [11:0]       i_awaddr,
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  output logic [1:0]             o_bresp,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  input  wire logic [11:0]       i_araddr,
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  output logic [31:0]            o_rdata,
  output logic [1:0]             o_rresp,
  output logic                   o_rvalid,
  input  wire logic              i_rready,
  input  wire logic              i_align_n,
  input  wire logic              i_lock_indicator_pin,
  input  wire logic              i_pfd_ref,
  input  wire logic              i_err_in_lock_win,
  input  wire logic              i_err_over_unlock,
  input  wire logic              i_autoload_done,
  input  wire logic              i_ext_clk_sel,
  input  wire logic              i_primary_reference_slow,
  input  wire logic              i_secondary_reference_slow,
  input  wire logic              i_vco_slow,
  input  wire logic              i_clkin_slow,
  output logic                   o_cp_hiz,
  output logic                   o_bcnt_reset,
  output logic                   o_phase_lock_detector,
  output logic                   o_charged_lock_detect,
  output logic [5:0]             o_lock_pin_mode,
  output logic                   o_ref_monitor_extended,
  output logic [7:0]             o_ref_sel,
  output logic [3:0]             o_ignore_align,
  output logic                   o_internal_align,
  output logic                   o_loop_open
);
  import pllhc_pkg::*;

  pllhc_byte_t  pll_cfg_reg;
  pllhc_byte_t  pin_ctl_reg;
  pllhc_byte_t  ref_sel_reg;
  pllhc_byte_t  ho_ctl_reg;
  logic [3:0]   ign_reg;
  logic         cal_act_reg;
  logic         done_reg;
  logic         hiz_reg;
  logic         armed_reg;
  logic         align_prev_reg;
  logic         bcnt_reg;
  logic         lock_reg;
  logic [7:0]   good_cnt_reg;
  logic [3:0]   div_cnt_reg;
  logic [12:0]  tick_cnt_reg;
  logic [3:0]   mon_reg;
  pllhc_cal_e   cal_state_reg;
  pllhc_cal_e   cal_state_next;
  logic         wr_go;
  logic [9:0]   wr_idx;
  logic [9:0]   rd_idx;
  logic         update_go;
  logic         cal_start;
  logic         cal_tick;
  logic         ho_en;
  logic         ho_ext;
  logic         pin_sensed;
  logic         enter_ho;
  logic         leave_ho;
  logic [7:0]   lock_target;
  logic [3:0]   div_last;
  logic [31:0]  rd_word;
  logic         rd_hit;
  logic         wr_hit;

  // write path takes address and data in the same beat
  assign wr_go     = i_awvalid & i_wvalid & ~o_bvalid & i_ce;
  assign o_awready = wr_go;
  assign o_wready  = wr_go;
  assign o_arready = ~o_rvalid & i_ce;
  assign wr_idx    = i_awaddr[11:2];
  assign rd_idx    = i_araddr[11:2];
  assign update_go = wr_go & i_wstrb[0] & (wr_idx == `PLLHC_IDX_UPDATE)
                     & i_wdata[0];

  // decode of mapped write addresses; others answer slverr
  always_comb begin
    case (wr_idx)
      `PLLHC_IDX_PLL_CFG, `PLLHC_IDX_PIN_CTL, `PLLHC_IDX_REF_SEL,
      `PLLHC_IDX_HO_CTL, `PLLHC_IDX_STATUS, `PLLHC_IDX_CH0,
      `PLLHC_IDX_CH1, `PLLHC_IDX_CH2, `PLLHC_IDX_CH3,
      `PLLHC_IDX_UPDATE: wr_hit = 1'b1;
      default:           wr_hit = 1'b0;
    endcase
  end

  // configuration registers; data sits in the low byte lane
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pll_cfg_reg <= `PLLHC_RST_BYTE;
      pin_ctl_reg <= `PLLHC_RST_BYTE;
      ref_sel_reg <= `PLLHC_RST_BYTE;
      ho_ctl_reg  <= `PLLHC_RST_BYTE;
      ign_reg     <= 4'h0;
    end else if (wr_go && i_wstrb[0]) begin
      case (wr_idx)
        `PLLHC_IDX_PLL_CFG: pll_cfg_reg <= i_wdata[7:0];
        `PLLHC_IDX_PIN_CTL: pin_ctl_reg <= i_wdata[7:0];
        `PLLHC_IDX_REF_SEL: ref_sel_reg <= i_wdata[7:0];
        `PLLHC_IDX_HO_CTL:  ho_ctl_reg  <= i_wdata[7:0];
        `PLLHC_IDX_CH0: ign_reg[0] <= i_wdata[`PLLHC_IGN_BIT];
        `PLLHC_IDX_CH1: ign_reg[1] <= i_wdata[`PLLHC_IGN_BIT];
        `PLLHC_IDX_CH2: ign_reg[2] <= i_wdata[`PLLHC_IGN_BIT];
        `PLLHC_IDX_CH3: ign_reg[3] <= i_wdata[`PLLHC_IGN_BIT];
        default: ;
      endcase
    end
  end

  // write response
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_bvalid <= 1'b0;
      o_bresp  <= 2'h0;
    end else if (i_ce) begin
      if (wr_go) begin
        o_bvalid <= 1'b1;
        o_bresp  <= wr_hit ? 2'h0 : 2'h2;
      end else if (i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // read mux; status shows live block state
  always_comb begin
    rd_word = 32'h0;
    rd_hit  = 1'b1;
    case (rd_idx)
      `PLLHC_IDX_PLL_CFG: rd_word[7:0] = pll_cfg_reg;
      `PLLHC_IDX_PIN_CTL: rd_word[7:0] = pin_ctl_reg;
      `PLLHC_IDX_REF_SEL: rd_word[7:0] = ref_sel_reg;
      `PLLHC_IDX_HO_CTL:  rd_word[7:0] = ho_ctl_reg;
      `PLLHC_IDX_STATUS: begin
        rd_word[3:0]                = mon_reg;
        rd_word[`PLLHC_ST_HIZ_BIT]  = hiz_reg;
        rd_word[`PLLHC_ST_BUSY_BIT] = cal_state_reg != PLLHC_CS_IDLE;
        rd_word[`PLLHC_ST_DONE_BIT] = done_reg;
      end
      `PLLHC_IDX_CH0: rd_word[`PLLHC_IGN_BIT] = ign_reg[0];
      `PLLHC_IDX_CH1: rd_word[`PLLHC_IGN_BIT] = ign_reg[1];
      `PLLHC_IDX_CH2: rd_word[`PLLHC_IGN_BIT] = ign_reg[2];
      `PLLHC_IDX_CH3: rd_word[`PLLHC_IGN_BIT] = ign_reg[3];
      `PLLHC_IDX_UPDATE: rd_word = 32'h0; // self-clearing command
      default: rd_hit = 1'b0;
    endcase
  end

  // read data channel
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_rvalid <= 1'b0;
      o_rdata  <= 32'h0;
      o_rresp  <= 2'h0;
    end else if (i_ce) begin
      if (i_arvalid && !o_rvalid) begin
        o_rvalid <= 1'b1;
        o_rdata  <= rd_word;
        o_rresp  <= rd_hit ? 2'h0 : 2'h2;
      end else if (i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  // monitors: vco monitor watches clk input when that is selected
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      mon_reg <= 4'h0;
    end else if (i_ce) begin
      mon_reg[`PLLHC_ST_PRI_BIT]  <= i_primary_reference_slow;
      mon_reg[`PLLHC_ST_SEC_BIT]  <= i_secondary_reference_slow;
      mon_reg[`PLLHC_ST_VCO_BIT]  <= i_ext_clk_sel ? i_clkin_slow : i_vco_slow;
      mon_reg[`PLLHC_ST_LOCK_BIT] <= lock_reg;
    end
  end

  assign o_ref_monitor_extended = pin_ctl_reg[`PLLHC_REFTHR_BIT];
  assign o_lock_pin_mode        = pin_ctl_reg[5:0];
  assign o_charged_lock_detect  = pin_ctl_reg[5:0] == `PLLHC_PIN_CHARGED;
  assign o_ref_sel              = ref_sel_reg;
  assign o_ignore_align         = ign_reg;
  assign o_phase_lock_detector  = lock_reg;

  // lock detector target from the two-bit counter field
  always_comb begin
    case (pll_cfg_reg[`PLLHC_LDC_LSB +: 2])
      2'h0:    lock_target = `PLLHC_LDC0;
      2'h1:    lock_target = `PLLHC_LDC1;
      2'h2:    lock_target = `PLLHC_LDC2;
      default: lock_target = `PLLHC_LDC3;
    endcase
  end

  // hysteresis: one bad cycle drops lock, a run of good ones sets it
  always_ff @(posedge i_clk) begin
    if (i_srst || (i_ce && pll_cfg_reg[`PLLHC_DET_DIS_BIT])) begin
      lock_reg     <= 1'b0;
      good_cnt_reg <= 8'h00;
    end else if (i_ce && i_pfd_ref) begin
      if (i_err_over_unlock) begin
        lock_reg     <= 1'b0;
        good_cnt_reg <= 8'h00;
      end else if (!i_err_in_lock_win) begin
        good_cnt_reg <= 8'h00;
      end else if (good_cnt_reg + 8'h01 >= lock_target) begin
        lock_reg     <= 1'b1;
        good_cnt_reg <= lock_target;
      end else begin
        good_cnt_reg <= good_cnt_reg + 8'h01;
      end
    end
  end

  // holdover decision; detector events come from the selected reference
  assign ho_en     = ho_ctl_reg[`PLLHC_HO_EN_BIT];
  assign ho_ext    = ho_ctl_reg[`PLLHC_HO_EXT_BIT];
  assign pin_sensed = ho_ctl_reg[`PLLHC_COMP_EN_BIT] ? i_lock_indicator_pin
                                                     : 1'b1;
  // automatic entry only from a normal pump, so a pin still low cannot block release
  assign enter_ho   = i_ce & ho_en
                      & (ho_ext ? (align_prev_reg & ~i_align_n)
                                : (armed_reg & ~hiz_reg & ~pin_sensed));
  assign leave_ho  = i_ce & hiz_reg & i_pfd_ref & ~enter_ho
                     & (~ho_ext | i_align_n);
  // entry reaches the pump in the same cycle as the edge
  assign o_cp_hiz     = hiz_reg | enter_ho;
  assign o_bcnt_reset = bcnt_reg;

  // edge detector memory for the alignment pin
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      align_prev_reg <= 1'b1;
    end else if (i_ce) begin
      align_prev_reg <= i_align_n;
    end
  end

  // pump state; clearing enable returns the pump to normal at once
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      hiz_reg  <= 1'b0;
      bcnt_reg <= 1'b0;
    end else if (i_ce) begin
      bcnt_reg <= leave_ho & ho_en;
      if (!ho_en) begin
        hiz_reg <= 1'b0;
      end else if (enter_ho) begin
        hiz_reg <= 1'b1;
      end else if (leave_ho) begin
        hiz_reg <= 1'b0;
      end
    end
  end

  // re-arm only once the pin is seen high out of holdover
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      armed_reg <= 1'b1;
    end else if (i_ce) begin
      if (leave_ho && !ho_ext) begin
        armed_reg <= 1'b0;
      end else if (!hiz_reg && pin_sensed) begin
        armed_reg <= 1'b1;
      end
    end
  end

  // calibrate bit acts on update; a rising active copy starts a run
  assign cal_start = i_ce & ((update_go & pll_cfg_reg[`PLLHC_CAL_BIT]
                     & ~cal_act_reg) | i_autoload_done);
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cal_act_reg <= 1'b0; // first set-and-update starts a run
    end else if (i_ce && update_go) begin
      cal_act_reg <= pll_cfg_reg[`PLLHC_CAL_BIT];
    end
  end

  // calibration clock: detector events divided by 2,4,8 or 16
  assign div_last = 4'((5'h02 << pll_cfg_reg[`PLLHC_CALDIV_LSB +: 2]) - 5'h01);
  assign cal_tick = i_ce & i_pfd_ref & (div_cnt_reg == div_last);
  always_ff @(posedge i_clk) begin
    if (i_srst || cal_state_reg == PLLHC_CS_IDLE) begin
      div_cnt_reg <= 4'h0;
    end else if (i_ce && i_pfd_ref) begin
      div_cnt_reg <= (div_cnt_reg == div_last) ? 4'h0 : div_cnt_reg + 4'h1;
    end
  end

  // sequencer; without a reference no tick arrives and it waits
  always_comb begin
    cal_state_next = cal_state_reg;
    case (cal_state_reg)
      PLLHC_CS_IDLE:    if (cal_start) cal_state_next = PLLHC_CS_ALIGN;
      PLLHC_CS_ALIGN:   if (cal_tick) cal_state_next = PLLHC_CS_RUN;
      PLLHC_CS_RUN:     if (cal_tick && tick_cnt_reg == 13'(CAL_TICKS - 3))
                          cal_state_next = PLLHC_CS_RELEASE;
      PLLHC_CS_RELEASE: if (cal_tick) cal_state_next = PLLHC_CS_CLOSE;
      PLLHC_CS_CLOSE:   cal_state_next = PLLHC_CS_IDLE;
      default:          cal_state_next = PLLHC_CS_IDLE;
    endcase
  end

  // state register and tick count over the RUN state only
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cal_state_reg <= PLLHC_CS_IDLE;
      tick_cnt_reg  <= 13'h0000;
    end else if (i_ce) begin
      cal_state_reg <= cal_state_next;
      if (cal_state_reg == PLLHC_CS_IDLE) begin
        tick_cnt_reg <= 13'h0000;
      end else if (cal_tick && cal_state_reg == PLLHC_CS_RUN) begin
        tick_cnt_reg <= tick_cnt_reg + 13'h0001;
      end
    end
  end

  // outputs held static until vco settled; loop closes last
  assign o_internal_align = cal_state_reg == PLLHC_CS_ALIGN
                            || cal_state_reg == PLLHC_CS_RUN;
  assign o_loop_open      = cal_state_reg != PLLHC_CS_IDLE
                            && cal_state_reg != PLLHC_CS_CLOSE;

  // done flag: start clears it, the close step sets it
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      done_reg <= 1'b0;
    end else if (i_ce) begin
      if (cal_state_reg == PLLHC_CS_CLOSE) begin
        done_reg <= 1'b1;
      end else if (cal_start && cal_state_reg == PLLHC_CS_IDLE) begin
        done_reg <= 1'b0;
      end
    end
  end

  property p_ho_off;
    @(posedge i_clk) disable iff (i_srst) i_ce && !ho_en |=> !hiz_reg;
  endproperty
  a_ho_off: assert property (p_ho_off) else $error("hiz with holdover off");
  property p_fall;
    @(posedge i_clk) disable iff (i_srst)
      i_ce && ho_en && ho_ext && align_prev_reg && !i_align_n |-> o_cp_hiz;
  endproperty
  a_fall: assert property (p_fall) else $error("edge missed hiz");
  property p_wait_ref;
    @(posedge i_clk) disable iff (i_srst)
      i_ce && ho_en && hiz_reg && !i_pfd_ref |=> hiz_reg;
  endproperty
  a_wait_ref: assert property (p_wait_ref) else $error("left hiz early");
  property p_bcnt;
    @(posedge i_clk) disable iff (i_srst)
      o_bcnt_reset |-> $past(hiz_reg) && !hiz_reg && $past(i_pfd_ref);
  endproperty
  a_bcnt: assert property (p_bcnt) else $error("b reset not on release");
  property p_auto;
    @(posedge i_clk) disable iff (i_srst)
      i_ce && ho_en && !ho_ext && armed_reg && !hiz_reg && !pin_sensed |=> hiz_reg;
  endproperty
  a_auto: assert property (p_auto) else $error("auto holdover missed");
  property p_comp;
    @(posedge i_clk) disable iff (i_srst)
      i_ce && !ho_ctl_reg[`PLLHC_COMP_EN_BIT] && !ho_ext && !hiz_reg |=> !hiz_reg;
  endproperty
  a_comp: assert property (p_comp) else $error("entered with comp off");
  property p_rearm;
    @(posedge i_clk) disable iff (i_srst) leave_ho && !ho_ext |=> !armed_reg;
  endproperty
  a_rearm: assert property (p_rearm) else $error("armed after release");
  property p_unlock;
    @(posedge i_clk) disable iff (i_srst)
      i_ce && i_pfd_ref && i_err_over_unlock |=> !lock_reg;
  endproperty
  a_unlock: assert property (p_unlock) else $error("lock kept");
  property p_done_clr;
    @(posedge i_clk) disable iff (i_srst)
      cal_start && cal_state_reg == PLLHC_CS_IDLE |=> !done_reg [*2];
  endproperty
  a_done_clr: assert property (p_done_clr) else $error("done not cleared");
  property p_seq;
    @(posedge i_clk) disable iff (i_srst)
      cal_state_reg == PLLHC_CS_CLOSE |-> $past(cal_state_reg) == PLLHC_CS_RELEASE
        && !o_internal_align;
  endproperty
  a_seq: assert property (p_seq) else $error("bad cal order");
endmodule

// ===== testbench/pllhc_ref_model.sv
`timescale 1ns/1ps
module pllhc_ref_model #(
  parameter int PERIOD = 4,
  parameter int CHARGE = 20
) (
  input  wire logic i_clk,
  input  wire logic i_srst,
  input  wire logic i_ref_on,
  input  wire logic i_bad_phase,
  input  wire logic i_lock,
  output logic      o_pfd_ref,
  output logic      o_in_win,
  output logic      o_over_unlock,
  output logic      o_lock_pin
);
  int ph_reg;
  int chg_reg;
  // detector edges only while a reference is present
  always_ff @(posedge i_clk) begin
    if (i_srst || !i_ref_on) begin
      ph_reg <= 0;
      o_pfd_ref <= 1'b0;
    end else begin
      ph_reg <= (ph_reg == PERIOD - 1) ? 0 : ph_reg + 1;
      o_pfd_ref <= (ph_reg == PERIOD - 1);
    end
  end
  // qualifiers mean nothing between pulses, so they toggle there
  assign o_in_win = o_pfd_ref ? !i_bad_phase : ph_reg[0];
  assign o_over_unlock = o_pfd_ref ? i_bad_phase : !ph_reg[0];
  // capacitor charges slowly while locked, dumps at once on unlock
  always_ff @(posedge i_clk) begin
    if (i_srst || !i_lock) begin
      chg_reg <= 0;
    end else if (chg_reg < CHARGE) begin
      chg_reg <= chg_reg + 1;
    end
  end
  assign o_lock_pin = (chg_reg == CHARGE);
endmodule

// ===== testbench/pllhc_tb_top.sv
`timescale 1ns/1ps
`include "pllhc_regs.svh"
module pllhc_tb_top;
  import pllhc_pkg::*;
  localparam int CAL = 8;
  logic clk = 1'b0, srst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, align_n = 1'b1, autoload = 1'b0, ext_sel = 1'b0;
  logic ref_on = 1'b0, bad = 1'b0;
  logic [3:0] slow = 4'h0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h00000000, rdata, st;
  logic [1:0] bresp, rresp, resp;
  logic awready, wready, bvalid, arready, rvalid, hiz, bcnt, lock, chg, refext, ialign, lopen;
  logic pfd, inwin, over, lpin;
  logic [5:0] ldmode;
  logic [7:0] refsel;
  logic [3:0] ign;
  int seed = 40364, fails = 0, tests_run = 0, pulses = 0, n, cnt, p0;
  logic [1:0] dv;
  logic [7:0] rv;
  always #4 clk = ~clk;
  always @(posedge clk) if (pfd === 1'b1) pulses <= pulses + 1;
  pllhc_top #(.CAL_TICKS(CAL)) pllhc_top_inst (.i_clk(clk), .i_srst(srst), .i_ce(1'b1),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
    .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_align_n(align_n),
    .i_lock_indicator_pin(lpin), .i_pfd_ref(pfd), .i_err_in_lock_win(inwin),
    .i_err_over_unlock(over), .i_autoload_done(autoload), .i_ext_clk_sel(ext_sel),
    .i_primary_reference_slow(slow[0]), .i_secondary_reference_slow(slow[1]),
    .i_vco_slow(slow[2]), .i_clkin_slow(slow[3]), .o_cp_hiz(hiz), .o_bcnt_reset(bcnt),
    .o_phase_lock_detector(lock), .o_charged_lock_detect(chg), .o_lock_pin_mode(ldmode),
    .o_ref_monitor_extended(refext), .o_ref_sel(refsel), .o_ignore_align(ign),
    .o_internal_align(ialign), .o_loop_open(lopen));
  pllhc_ref_model pllhc_ref_model_inst (.i_clk(clk), .i_srst(srst), .i_ref_on(ref_on),
    .i_bad_phase(bad), .i_lock(lock), .o_pfd_ref(pfd), .o_in_win(inwin),
    .o_over_unlock(over), .o_lock_pin(lpin));
  function automatic logic [11:0] ba(input logic [9:0] idx);
    return {idx, 2'b00};
  endfunction
  // pulses per calibration: ticks times the divider
  function automatic int cal_pulses(input logic [1:0] d);
    return CAL * (2 << d);
  endfunction
  task automatic stop_test();
    $display("mismatches %0d of %0d comparisons", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // a hang is turned into a mismatch and ends the run
  task automatic tmo(input logic hit);
    if (hit) begin
      fails++;
      $display("CHECK FAILED t=%0t wait ran out", $time);
      stop_test();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // valid stands until the edge that takes it, then drops at once
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (n < 200 && !(awready === 1'b1 && wready === 1'b1));
    tmo(!(awready === 1'b1 && wready === 1'b1));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    for (n = 0; n < 200 && bvalid !== 1'b1; n++) @(posedge clk);
    tmo(n >= 200);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (n < 200 && arready !== 1'b1);
    tmo(arready !== 1'b1);
    arvalid <= 1'b0;
    for (n = 0; n < 200 && rvalid !== 1'b1; n++) @(posedge clk);
    tmo(n >= 200);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic wait_hiz(input logic lvl);
    for (cnt = 0; cnt < 2000 && hiz !== lvl; cnt++) @(posedge clk);
    tmo(cnt >= 2000);
  endtask
  // pfd pulses from start to loop closure, and align released before the loop closes
  task automatic cal_check(input logic [1:0] d, input int p0);
    int ca;
    rd(ba(`PLLHC_IDX_STATUS), st);
    check(32'(st[6:5]), 32'h1);
    check(32'(ialign), 32'h1);
    ca = -1;
    for (cnt = 0; cnt < 5000 && lopen === 1'b1; cnt++) begin
      @(posedge clk);
      if (ialign === 1'b0 && ca < 0) ca = cnt;
    end
    tmo(cnt >= 5000);
    check(32'(ca >= 0 && ca < cnt), 32'h1);
    n = pulses - p0;
    check(32'(n >= cal_pulses(d) - (2 << d) && n <= cal_pulses(d) + (2 << d)), 32'h1);
    repeat (2) @(posedge clk);
    rd(ba(`PLLHC_IDX_STATUS), st);
    check(32'(st[6:5]), 32'h2);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    rd(ba(`PLLHC_IDX_STATUS), st);
    check(st, 32'h0);
    rd(12'h004, st);
    check({30'h0, resp}, 32'h2);
    rv = 8'($random(seed));
    wr(ba(`PLLHC_IDX_REF_SEL), {24'h0, rv});
    check(32'(refsel), 32'(rv));
    rv = 8'($random(seed));
    wr(ba(`PLLHC_IDX_CH0), {25'h0, rv[0], 6'h0});
    wr(ba(`PLLHC_IDX_CH1), {25'h0, rv[1], 6'h0});
    wr(ba(`PLLHC_IDX_CH2), {25'h0, rv[2], 6'h0});
    wr(ba(`PLLHC_IDX_CH3), {25'h0, rv[3], 6'h0});
    check(32'(ign), 32'(rv[3:0]));
    wr(ba(`PLLHC_IDX_PIN_CTL), 32'h44);
    check({refext, chg, ldmode}, 32'hC4);
    wr(ba(`PLLHC_IDX_PIN_CTL), 32'h05);
    check({refext, chg}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      slow <= 4'($random(seed));
      ext_sel <= 1'($random(seed));
      repeat (3) @(posedge clk);
      rd(ba(`PLLHC_IDX_STATUS), st);
      check(32'(st[2:0]), 32'({ext_sel ? slow[3] : slow[2], slow[1:0]}));
    end
    // external bit set, enable clear: the pin edge is ignored
    wr(ba(`PLLHC_IDX_HO_CTL), 32'h02);
    align_n <= 1'b0;
    repeat (5) @(posedge clk);
    check(32'(hiz), 32'h0);
    wr(ba(`PLLHC_IDX_HO_CTL), 32'h03);
    repeat (5) @(posedge clk);
    check(32'(hiz), 32'h0);
    // detector stays enabled so the lock count is meaningful
    wr(ba(`PLLHC_IDX_PLL_CFG), 32'h00);
    ref_on <= 1'b1;
    cnt = 0;
    for (n = 0; n < 500 && lock !== 1'b1; n++) begin
      @(posedge clk);
      if (pfd === 1'b1 && inwin === 1'b1) cnt++;
    end
    check(cnt, 32'(`PLLHC_LDC0));
    bad <= 1'b1;
    cnt = 0;
    for (n = 0; n < 500 && lock !== 1'b0; n++) begin
      @(posedge clk);
      if (pfd === 1'b1 && over === 1'b1) cnt++;
    end
    check(cnt, 32'h1);
    bad <= 1'b0;
    align_n <= 1'b1;
    for (cnt = 0; cnt < 500 && lpin !== 1'b1; cnt++) @(posedge clk);
    tmo(cnt >= 500);
    align_n <= 1'b0;
    @(posedge clk);
    #1 check(32'(hiz), 32'h1);
    repeat (20) @(posedge clk);
    check(32'(hiz), 32'h1);
    ref_on <= 1'b0;
    align_n <= 1'b1;
    repeat (20) @(posedge clk);
    check(32'(hiz), 32'h1);
    ref_on <= 1'b1;
    wait_hiz(1'b0);
    check(32'(bcnt), 32'h1);
    @(posedge clk);
    check(32'(bcnt), 32'h0);
    wr(ba(`PLLHC_IDX_HO_CTL), 32'h09);
    bad <= 1'b1;
    wait_hiz(1'b1);
    ref_on <= 1'b0;
    bad <= 1'b0;
    repeat (20) @(posedge clk);
    check(32'(hiz), 32'h1);
    ref_on <= 1'b1;
    wait_hiz(1'b0);
    check(32'(bcnt), 32'h1);
    rv = 8'h0;
    for (cnt = 0; cnt < 500 && lpin !== 1'b1; cnt++) begin
      @(posedge clk);
      if (hiz !== 1'b0) rv = 8'h1;
    end
    tmo(cnt >= 500);
    check(32'(rv), 32'h0);
    bad <= 1'b1;
    wait_hiz(1'b1);
    wr(ba(`PLLHC_IDX_HO_CTL), 32'h08);
    @(posedge clk);
    check(32'(hiz), 32'h0);
    bad <= 1'b0;
    for (cnt = 0; cnt < 500 && lpin !== 1'b1; cnt++) @(posedge clk);
    tmo(cnt >= 500);
    wr(ba(`PLLHC_IDX_HO_CTL), 32'h01);
    bad <= 1'b1;
    align_n <= 1'b0;
    repeat (30) @(posedge clk);
    check(32'({lpin, hiz}), 32'h0);
    bad <= 1'b0;
    align_n <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      dv = 2'($random(seed));
      if (k == 1) begin
        wr(ba(`PLLHC_IDX_PLL_CFG), {29'h0, dv, 1'b1});
        wr(ba(`PLLHC_IDX_UPDATE), 32'h1);
        repeat (2) @(posedge clk);
        check(32'(lopen), 32'h0);
        wr(ba(`PLLHC_IDX_PLL_CFG), {29'h0, dv, 1'b0});
        wr(ba(`PLLHC_IDX_UPDATE), 32'h1);
      end
      wr(ba(`PLLHC_IDX_PLL_CFG), {29'h0, dv, 1'b1});
      p0 = pulses;
      wr(ba(`PLLHC_IDX_UPDATE), 32'h1);
      cal_check(dv, p0);
    end
    @(posedge clk);
    autoload <= 1'b1;
    n = pulses;
    @(posedge clk);
    autoload <= 1'b0;
    cal_check(dv, n);
    stop_test();
  end
endmodule
